// >>> core/tmc_regs.vh
// How it works
// [RULE1] Reading either count byte freezes both bytes
// [RULE2] Reset or count/control write unfreezes buffer
// [RULE3] Reset clears the counter
// [RULE4] Debug halt stops counter, buffer unchanged
// [RULE5] Up mode wraps to zero, sets overflow
// [RULE6] Center mode turns down at wrap, flags
// [RULE7] Half-written wrap value suppresses overflow flag
// [RULE8] Wrap resets zero; zero means full range
// [RULE9] Software updates wrap right after overflow; the code commits the wrap pair as soon as its second byte is written
// [RULE10] Capture mode flags selected pin edge
// [RULE11] Compare and edge PWM flag on match
// [RULE12] Center PWM flags every match
// [RULE13] Channel irq while flag and enable set
// [RULE14] Flag clears by read-then-write zero
// [RULE15] New event cancels pending clear sequence
// [RULE16] Irq enable read/write; reset clears both
// [RULE17] Mode B set selects edge PWM
// [RULE18] Mode A picks capture or compare
// [RULE19] Edge/level field sets polarity or action
// [RULE20] Edge/level zero releases the pin
// [RULE21] Capture: rising, falling or both edges
// [RULE22] Compare: none, toggle, clear, set
// [RULE23] PWM: 10 high-true, X1 low-true
// [RULE24] Counter steps on each prescaled tick
`ifndef TMC_REGS_VH
`define TMC_REGS_VH
`define TMC_ADDR_CNT_HI 12'h000
`define TMC_ADDR_CNT_LO 12'h004
`define TMC_ADDR_WRAP_HI 12'h008
`define TMC_ADDR_WRAP_LO 12'h00C
`define TMC_ADDR_TSC 12'h010
`define TMC_ADDR_CSC 12'h014
`define TMC_ADDR_CVAL 12'h018
`define TMC_BIT_FLAG 7
`define TMC_BIT_IE 6
`define TMC_BIT_MSB 5
`define TMC_BIT_MSA 4
`define TMC_BIT_ELB 3
`define TMC_BIT_ELA 2
`define TMC_TSC_BIT_OVF 7
`define TMC_TSC_BIT_CENTER 5
`define TMC_TSC_BIT_CLKA 3
`define TMC_RST_WRAP 16'h0000
`define TMC_RST_COUNT 16'h0000
`endif

// >>> core/tmc_timer.v
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
`include "tmc_regs.vh"
module tmc_timer (
	input wire clock,
	input wire reset,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire timer_tick,
	input wire debug_halt,
	input wire chan_pin_in,
	output reg chan_pin_out,
	output reg chan_pin_oe,
	output reg chan_irq,
	output reg overflow_irq
);
	// Counter and wrap state
	reg [15:0] count_ff;
	reg [15:0] wrap_ff;
	reg [15:0] wrap_buf_ff;
	reg [15:0] hold_ff;
	reg [15:0] cval_ff;
	reg dir_down_ff;
	reg latched_ff;
	reg latch_hi_ff;
	reg wrap_half_ff;
	// Timer control and overflow
	reg ovf_ff;
	reg ovf_armed_ff;
	reg ovf_ie_ff;
	reg center_ff;
	reg [1:0] clks_ff;
	// Channel control
	reg flag_ff;
	reg flag_armed_ff;
	reg ie_ff;
	reg msb_ff;
	reg msa_ff;
	reg elb_ff;
	reg ela_ff;
	// Synchronisers
	reg pin_s1_ff;
	reg pin_s2_ff;
	reg pin_d_ff;
	reg halt_s1_ff;
	reg halt_ff;
	// Next values and events
	reg [31:0] nxt_prdata;
	reg [15:0] nxt_count;
	reg nxt_dir_down;
	reg nxt_pin_out;
	reg ch_event;
	reg ovf_event;

	// Either counter byte
	function is_count_addr;
		input [11:0] a;
		begin
			is_count_addr = (a == `TMC_ADDR_CNT_HI) || (a == `TMC_ADDR_CNT_LO);
		end
	endfunction

	// Either wrap byte
	function is_wrap_addr;
		input [11:0] a;
		begin
			is_wrap_addr = (a == `TMC_ADDR_WRAP_HI) || (a == `TMC_ADDR_WRAP_LO);
		end
	endfunction

	// Word aligned offsets up to the channel value
	function is_mapped;
		input [11:0] a;
		begin
			is_mapped = (a[11:5] == 7'h00) && (a[4:0] <= 5'h18) && (a[1:0] == 2'b00);
		end
	endfunction

	wire access;
	wire wr;
	wire rd;
	wire cnt_rd;
	wire cnt_wr;
	wire wrap_wr;
	wire tsc_rd;
	wire tsc_wr;
	wire csc_rd;
	wire csc_wr;
	wire cval_wr;
	wire [15:0] top;
	wire run;
	wire at_top;
	wire match;
	wire pin_used;
	wire rise;
	wire fall;
	wire pwm_mode;
	wire capture_mode;

	// Writes and reads act at the end of the access cycle, on the same edge that raises ready
	assign access = psel && penable && !pready;
	assign wr = access && pwrite;
	assign rd = access && !pwrite;
	assign cnt_rd = rd && is_count_addr(paddr);
	assign cnt_wr = wr && is_count_addr(paddr);
	assign wrap_wr = wr && is_wrap_addr(paddr);
	assign tsc_rd = rd && (paddr == `TMC_ADDR_TSC);
	assign tsc_wr = wr && (paddr == `TMC_ADDR_TSC);
	assign csc_rd = rd && (paddr == `TMC_ADDR_CSC);
	assign csc_wr = wr && (paddr == `TMC_ADDR_CSC);
	assign cval_wr = wr && (paddr == `TMC_ADDR_CVAL);
	// [RULE8] zero wrap means full range
	assign top = (wrap_ff == 16'h0000) ? 16'hFFFF : wrap_ff;
	// [RULE24] [RULE4] tick gate
	assign run = timer_tick && (clks_ff != 2'b00) && !halt_ff;
	assign at_top = (count_ff == top);
	assign match = run && (count_ff == cval_ff);
	assign pin_used = elb_ff || ela_ff;
	assign rise = pin_s2_ff && !pin_d_ff;
	assign fall = !pin_s2_ff && pin_d_ff;
	// [RULE17] [RULE18] mode decode
	assign pwm_mode = center_ff || msb_ff;
	assign capture_mode = !center_ff && !msb_ff && !msa_ff;

	always @* begin
		ovf_event = 1'b0;
		ch_event = 1'b0;
		if (run && !wrap_half_ff && at_top) begin
			// [RULE5] [RULE6] [RULE7] overflow at the top, upward only
			ovf_event = !center_ff || !dir_down_ff;
		end
		if (capture_mode) begin
			// [RULE10] [RULE20] [RULE21] selected edges
			ch_event = (ela_ff && rise) || (elb_ff && fall);
		end else begin
			// [RULE11] [RULE12] every match
			ch_event = match;
		end
	end

	// [RULE24] counter next value
	always @* begin
		nxt_count = count_ff;
		nxt_dir_down = dir_down_ff;
		if (run) begin
			if (!center_ff) begin
				// [RULE5] up wrap
				nxt_count = at_top ? 16'h0000 : count_ff + 16'h0001;
				nxt_dir_down = 1'b0;
			end else if (!dir_down_ff) begin
				// [RULE6] turn at the top
				if (at_top) begin
					nxt_count = count_ff - 16'h0001;
					nxt_dir_down = 1'b1;
				end else begin
					nxt_count = count_ff + 16'h0001;
				end
			end else begin
				if (count_ff == 16'h0000) begin
					nxt_count = 16'h0001;
					nxt_dir_down = 1'b0;
				end else begin
					nxt_count = count_ff - 16'h0001;
				end
			end
		end
		// A count write restarts the count as well
		if (cnt_wr) begin
			nxt_count = `TMC_RST_COUNT;
			nxt_dir_down = 1'b0;
		end
	end

	always @* begin
		nxt_prdata = 32'h00000000;
		case (paddr)
			`TMC_ADDR_CNT_HI: nxt_prdata[7:0] = latched_ff ? hold_ff[15:8] : count_ff[15:8];
			`TMC_ADDR_CNT_LO: nxt_prdata[7:0] = latched_ff ? hold_ff[7:0] : count_ff[7:0];
			`TMC_ADDR_WRAP_HI: nxt_prdata[7:0] = wrap_ff[15:8];
			`TMC_ADDR_WRAP_LO: nxt_prdata[7:0] = wrap_ff[7:0];
			`TMC_ADDR_TSC: nxt_prdata[7:0] = {ovf_ff, ovf_ie_ff, center_ff, clks_ff, 3'b000};
			`TMC_ADDR_CSC: nxt_prdata[7:0] = {flag_ff, ie_ff, msb_ff, msa_ff, elb_ff, ela_ff, 2'b00};
			`TMC_ADDR_CVAL: nxt_prdata[15:0] = cval_ff;
			default: nxt_prdata = 32'h00000000;
		endcase
	end

	// [RULE19] pin action by mode
	always @* begin
		nxt_pin_out = chan_pin_out;
		if (match && pin_used) begin
			if (pwm_mode) begin
				// [RULE23] inactive level on the up match, active on the down match
				nxt_pin_out = (center_ff && dir_down_ff) ? !ela_ff : ela_ff;
			end else if (msa_ff) begin
				// [RULE22] compare action
				case ({elb_ff, ela_ff})
					2'b01: nxt_pin_out = !chan_pin_out;
					2'b10: nxt_pin_out = 1'b0;
					2'b11: nxt_pin_out = 1'b1;
					default: nxt_pin_out = chan_pin_out;
				endcase
			end
		end else if (run && pwm_mode && pin_used && (count_ff == 16'h0000)
				&& !dir_down_ff) begin
			// Period start drives the active level
			nxt_pin_out = !ela_ff;
		end
	end

	// Register bus answer, one wait state
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready <= access;
			prdata <= rd ? nxt_prdata : prdata;
			pslverr <= access && !is_mapped(paddr);
		end
	end

	// Pin and halt pass two flip-flops; halt reads the second, pin edges compare the second with a third
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			pin_s1_ff <= 1'b0;
			pin_s2_ff <= 1'b0;
			pin_d_ff <= 1'b0;
			halt_s1_ff <= 1'b0;
			halt_ff <= 1'b0;
		end else begin
			pin_s1_ff <= chan_pin_in;
			pin_s2_ff <= pin_s1_ff;
			pin_d_ff <= pin_s2_ff;
			halt_s1_ff <= debug_halt;
			halt_ff <= halt_s1_ff;
		end
	end

	// [RULE3] counter and direction
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			count_ff <= `TMC_RST_COUNT;
			dir_down_ff <= 1'b0;
		end else begin
			count_ff <= nxt_count;
			dir_down_ff <= nxt_dir_down;
		end
	end

	// [RULE1] [RULE2] [RULE4] coherent read buffer
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			latched_ff <= 1'b0;
			latch_hi_ff <= 1'b0;
			hold_ff <= 16'h0000;
		end else if (cnt_wr || tsc_wr) begin
			latched_ff <= 1'b0;
		end else if (cnt_rd && !halt_ff) begin
			if (!latched_ff) begin
				latched_ff <= 1'b1;
				latch_hi_ff <= (paddr == `TMC_ADDR_CNT_HI);
				hold_ff <= count_ff;
			end else if (latch_hi_ff != (paddr == `TMC_ADDR_CNT_HI)) begin
				// Only the other byte releases the buffer
				latched_ff <= 1'b0;
			end
		end
	end

	// [RULE7] [RULE8] wrap value commits as a pair
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			wrap_ff <= `TMC_RST_WRAP;
			wrap_buf_ff <= `TMC_RST_WRAP;
			wrap_half_ff <= 1'b0;
		end else if (wrap_wr) begin
			if (!wrap_half_ff) begin
				wrap_half_ff <= 1'b1;
				if (paddr == `TMC_ADDR_WRAP_HI)
					wrap_buf_ff <= {pwdata[7:0], wrap_ff[7:0]};
				else
					wrap_buf_ff <= {wrap_ff[15:8], pwdata[7:0]};
			end else begin
				wrap_half_ff <= 1'b0;
				if (paddr == `TMC_ADDR_WRAP_HI)
					wrap_ff <= {pwdata[7:0], wrap_buf_ff[7:0]};
				else
					wrap_ff <= {wrap_buf_ff[15:8], pwdata[7:0]};
			end
		end
	end

	// Timer control bits
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			ovf_ie_ff <= 1'b0;
			center_ff <= 1'b0;
			clks_ff <= 2'b00;
		end else if (tsc_wr) begin
			ovf_ie_ff <= pwdata[6];
			center_ff <= pwdata[`TMC_TSC_BIT_CENTER];
			clks_ff <= pwdata[`TMC_TSC_BIT_CLKA + 1:`TMC_TSC_BIT_CLKA];
		end
	end

	// Overflow flag; set wins over a clear in the same cycle
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			ovf_ff <= 1'b0;
			ovf_armed_ff <= 1'b0;
		end else begin
			if (tsc_rd && ovf_ff)
				ovf_armed_ff <= 1'b1;
			if (ovf_event) begin
				ovf_ff <= 1'b1;
				ovf_armed_ff <= 1'b0;
			end else if (tsc_wr && ovf_armed_ff && !pwdata[`TMC_TSC_BIT_OVF]) begin
				ovf_ff <= 1'b0;
				ovf_armed_ff <= 1'b0;
			end
		end
	end

	// [RULE16] [RULE17] [RULE18] [RULE19] channel control bits
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			ie_ff <= 1'b0;
			msb_ff <= 1'b0;
			msa_ff <= 1'b0;
			elb_ff <= 1'b0;
			ela_ff <= 1'b0;
		end else if (csc_wr) begin
			ie_ff <= pwdata[`TMC_BIT_IE];
			msb_ff <= pwdata[`TMC_BIT_MSB];
			msa_ff <= pwdata[`TMC_BIT_MSA];
			elb_ff <= pwdata[`TMC_BIT_ELB];
			ela_ff <= pwdata[`TMC_BIT_ELA];
		end
	end

	// Channel value used by the match
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			cval_ff <= 16'h0000;
		end else if (cval_wr) begin
			cval_ff <= pwdata[15:0];
		end
	end

	// [RULE14] [RULE15] [RULE16] channel flag
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			flag_ff <= 1'b0;
			flag_armed_ff <= 1'b0;
		end else begin
			if (csc_rd && flag_ff)
				flag_armed_ff <= 1'b1;
			// A new event wins so no request is lost
			if (ch_event) begin
				flag_ff <= 1'b1;
				flag_armed_ff <= 1'b0;
			end else if (csc_wr && flag_armed_ff && !pwdata[`TMC_BIT_FLAG]) begin
				flag_ff <= 1'b0;
				flag_armed_ff <= 1'b0;
			end
		end
	end

	// [RULE13] requests and pin drive
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			chan_irq <= 1'b0;
			overflow_irq <= 1'b0;
			chan_pin_oe <= 1'b0;
			chan_pin_out <= 1'b0;
		end else begin
			chan_irq <= (flag_ff || ch_event) && ie_ff;
			overflow_irq <= (ovf_ff || ovf_event) && ovf_ie_ff;
			// [RULE20] pin released when field is zero
			chan_pin_oe <= pin_used && !capture_mode;
			chan_pin_out <= nxt_pin_out;
		end
	end
endmodule

// >>> tb/tmc_timer_monitor.sv
`timescale 1ns/1ps
module tmc_timer_monitor (
	input wire clock,
	input wire reset,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire debug_halt,
	input wire chan_irq,
	input wire overflow_irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	resp_pulse_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	resp_wait_a: assert property (psel && penable && !pready |=> pready)
		else $error("no answer after one wait state");
	resp_cause_a: assert property (pready |-> psel && penable)
		else $error("ready outside an access");
	err_resp_a: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
		else $error("error response malformed");
	reset_quiet_a: assert property ($fell(reset) |-> !pready && !chan_irq && !overflow_irq)
		else $error("outputs active after reset");
	halt_hold_a: assert property (debug_halt [*4] |-> !$rose(overflow_irq))
		else $error("overflow while halted");
	flag_clear_a: assert property ($fell(chan_irq) |->
		$past(pready && pwrite) || $past(pready && pwrite, 2))
		else $error("channel irq dropped without a write");
	ovf_clear_a: assert property ($fell(overflow_irq) |->
		$past(pready && pwrite) || $past(pready && pwrite, 2))
		else $error("overflow irq dropped without a write");
endmodule
bind tmc_timer tmc_timer_monitor i_tmc_timer_monitor (.clock(clock), .reset(reset),
	.psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .debug_halt(debug_halt), .chan_irq(chan_irq),
	.overflow_irq(overflow_irq));

// >>> tb/tmc_apb_master.sv
`timescale 1ns/1ps
module tmc_apb_master (
	input wire clock,
	input wire pready,
	input wire pslverr,
	input wire [31:0] prdata,
	output logic psel = 0,
	output logic penable = 0,
	output logic pwrite = 0,
	output logic [11:0] paddr = 0,
	output logic [31:0] pwdata = 0
);
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e, output logic to);
		to = 1;
		@(posedge clock);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1;
		for (int n = 0; n < 50; n++) begin
			@(posedge clock);
			if (pready === 1'b1) begin
				q = prdata;
				e = pslverr;
				to = 0;
				break;
			end
		end
		psel <= 0;
		penable <= 0;
		// Idle bus shows inverted values so stale data never looks valid
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
`include "tmc_regs.vh"
module testbench;
	logic clock = 0, reset = 1, timer_tick = 0, debug_halt = 0, chan_pin_in = 0;
	wire psel, penable, pwrite, pready, pslverr, chan_pin_out, chan_pin_oe, chan_irq, overflow_irq;
	wire [11:0] paddr;
	wire [31:0] pwdata, prdata;
	logic [31:0] q;
	logic err, to;
	int fails = 0, n_checks = 0;
	tmc_timer i_tmc_timer (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .timer_tick(timer_tick), .debug_halt(debug_halt),
		.chan_pin_in(chan_pin_in), .chan_pin_out(chan_pin_out), .chan_pin_oe(chan_pin_oe),
		.chan_irq(chan_irq), .overflow_irq(overflow_irq));
	tmc_apb_master i_tmc_apb_master (.clock(clock), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata));
	initial begin
		forever #20 clock = ~clock;
	end
	task summarize;
		if (fails == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task xf(input logic w, input logic [11:0] a, input logic [31:0] d);
		i_tmc_apb_master.xfer(w, a, d, q, err, to);
		if (to) begin
			fails++;
			summarize();
		end
	endtask
	task rc(input logic [11:0] a, input logic [7:0] exp);
		xf(0, a, 0);
		chk($sformatf("reg %h", a), q[7:0], exp);
	endtask
	// Ticks are one-cycle pulses, then the counter is left to settle
	task ticks(input int n);
		repeat (n) begin
			@(posedge clock);
			timer_tick <= 1;
			@(posedge clock);
			timer_tick <= 0;
		end
		repeat (4) @(posedge clock);
	endtask
	initial begin
		repeat (5) @(posedge clock);
		reset <= 0;
		rc(`TMC_ADDR_CSC, 8'h00);
		rc(`TMC_ADDR_WRAP_LO, 8'h00);
		rc(`TMC_ADDR_CNT_LO, 8'h00);
		xf(0, 12'h020, 0);
		chk("unmapped", {q[30:0], err}, 32'h1);
		xf(1, `TMC_ADDR_TSC, 32'h48);
		xf(1, `TMC_ADDR_CNT_LO, 0);
		ticks(3);
		rc(`TMC_ADDR_CNT_HI, 8'h00);
		ticks(2);
		rc(`TMC_ADDR_CNT_LO, 8'h03);
		rc(`TMC_ADDR_CNT_LO, 8'h05);
		rc(`TMC_ADDR_CNT_HI, 8'h00);
		debug_halt <= 1;
		repeat (4) @(posedge clock);
		ticks(3);
		rc(`TMC_ADDR_CNT_LO, 8'h05);
		debug_halt <= 0;
		xf(1, `TMC_ADDR_CNT_LO, 0);
		xf(1, `TMC_ADDR_WRAP_HI, 0);
		xf(1, `TMC_ADDR_WRAP_LO, 3);
		ticks(5);
		rc(`TMC_ADDR_TSC, 8'hC8);
		chk("ovf_irq", overflow_irq, 1);
		xf(1, `TMC_ADDR_TSC, 32'h48);
		xf(1, `TMC_ADDR_WRAP_HI, 0);
		ticks(4);
		rc(`TMC_ADDR_TSC, 8'h48);
		xf(1, `TMC_ADDR_WRAP_LO, 3);
		ticks(4);
		rc(`TMC_ADDR_TSC, 8'hC8);
		xf(1, `TMC_ADDR_CVAL, 2);
		xf(1, `TMC_ADDR_CSC, 32'h5C);
		// The match is seen on the tick that leaves the matching count
		ticks(2);
		rc(`TMC_ADDR_CSC, 8'hDC);
		chk("irq", chan_irq, 1);
		chk("pin", {chan_pin_oe, chan_pin_out}, 3);
		ticks(4);
		xf(1, `TMC_ADDR_CSC, 32'h5C);
		rc(`TMC_ADDR_CSC, 8'hDC);
		xf(1, `TMC_ADDR_CSC, 32'h5C);
		rc(`TMC_ADDR_CSC, 8'h5C);
		chk("irq", chan_irq, 0);
		xf(1, `TMC_ADDR_CSC, 32'hDC);
		rc(`TMC_ADDR_CSC, 8'h5C);
		xf(1, `TMC_ADDR_CSC, 32'h50);
		@(posedge clock);
		chk("oe", chan_pin_oe, 0);
		xf(1, `TMC_ADDR_CSC, 32'h04);
		chan_pin_in <= 1;
		repeat (5) @(posedge clock);
		rc(`TMC_ADDR_CSC, 8'h84);
		xf(1, `TMC_ADDR_CSC, 32'h04);
		chan_pin_in <= 0;
		repeat (5) @(posedge clock);
		rc(`TMC_ADDR_CSC, 8'h04);
		xf(1, `TMC_ADDR_CSC, 32'h08);
		xf(1, `TMC_ADDR_TSC, 32'h68);
		xf(1, `TMC_ADDR_CNT_LO, 0);
		ticks(5);
		rc(`TMC_ADDR_CNT_LO, 8'h01);
		rc(`TMC_ADDR_CNT_HI, 8'h00);
		rc(`TMC_ADDR_TSC, 8'hE8);
		rc(`TMC_ADDR_CSC, 8'h88);
		chk("pin", {chan_pin_oe, chan_pin_out}, 3);
		xf(1, `TMC_ADDR_TSC, 32'h48);
		xf(1, `TMC_ADDR_CSC, 32'h28);
		xf(1, `TMC_ADDR_CNT_LO, 0);
		ticks(3);
		chk("pin", {chan_pin_oe, chan_pin_out}, 2);
		summarize();
	end
endmodule
